/* bst_if.sv */
`timescale 1ns/100ps

interface bst_if;
  logic tck;
  logic tms;
  logic tms_oe;
  logic tdi;
  logic tdi_oe;
  logic tdo;
  logic tdo_oe;
  logic tms_pin;
  logic tdi_pin;

  // internal pull-ups: an undriven mode or data input reads high
  assign tms_pin = tms_oe ? tms : 1'b1;
  assign tdi_pin = tdi_oe ? tdi : 1'b1;

  modport dev (
    input  tck,
    input  tms_pin,
    input  tdi_pin,
    output tdo,
    output tdo_oe
  );

  modport host (
    output tck,
    output tms,
    output tms_oe,
    output tdi,
    output tdi_oe,
    input  tdo,
    input  tdo_oe
  );
endinterface

/* bst_params.svh */
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH

// register widths
`define BST_IR_W            3
`define BST_ID_W            32
`define BST_BSR_W           24

// instruction codes
`define BST_IR_EXTEST       3'h0
`define BST_IR_IDCODE       3'h1
`define BST_IR_SAMPLE_Z     3'h2
`define BST_IR_SAMPLE       3'h4
`define BST_IR_BYPASS       3'h7

// pattern loaded into the instruction shifter on capture
`define BST_IR_CAPTURE      3'h1

// identification word, value is arbitrary (bit 0 set as usual)
`define BST_ID_VALUE        32'h0A5A5001

// reset values
`define BST_BSR_RESET       24'h000000

// tms-high rising edges that force test-logic reset
`define BST_RESET_TMS_EDGES 5

// timing: system clock, fastest test clock, host half period
`define BST_CLK_NS          25
`define BST_TCK_MIN_NS      50
`define BST_TCK_HALF_NS     100
`define BST_TCK_HALF_CYC    ((`BST_TCK_HALF_NS + `BST_CLK_NS - 1) / `BST_CLK_NS)

`endif

/* bst_pkg.sv */
`include "bst_params.svh"

package bst_pkg;

  // sixteen controller states
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } bst_tap_e;

  // host sequencing phases
  typedef enum logic [3:0] {
    H_IDLE, H_RST, H_RTI, H_GO, H_SDR, H_SIR, H_CAP, H_SHIFT, H_EXIT,
    H_UPD, H_END
  } bst_phase_e;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } bst_sync_s;

  typedef struct packed {
    bst_tap_e                st;
    logic [`BST_IR_W-1:0]    ir;
    logic [`BST_IR_W-1:0]    ir_sh;
    logic                    byp;
    logic [`BST_ID_W-1:0]    idr;
    logic [`BST_BSR_W-1:0]   bsr;
    logic [`BST_BSR_W-1:0]   bsr_upd;
    logic                    tdo;
    logic                    tdo_oe;
  } bst_dev_s;

  typedef struct packed {
    bst_phase_e              ph;
    logic                    tck;
    logic                    tms;
    logic                    tdi;
    logic [2:0]              div;
    logic [5:0]              cnt;
    logic [5:0]              len;
    logic                    is_ir;
    logic [31:0]             din;
    logic [31:0]             dout;
    logic                    done;
  } bst_host_s;

endpackage

/* bst_sync.sv */
`timescale 1ns/100ps

module bst_sync
  import bst_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input  wire logic CLK,
  input  wire logic SRST,
  input  wire logic D,
  output      logic Q,
  output      logic RISE,
  output      logic FALL
);

  bst_sync_s q_ff;
  bst_sync_s nxt_q;

  // two-stage synchroniser, third stage only for edge finding
  always_comb begin
    nxt_q    = q_ff;
    nxt_q.s1 = D;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      q_ff <= '{s1: INIT, s2: INIT, s3: INIT};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // edges from second and third stages only
  assign Q    = q_ff.s2;
  assign RISE = q_ff.s2 & ~q_ff.s3;
  assign FALL = ~q_ff.s2 & q_ff.s3;

endmodule

/* bst_tap_dev.sv */
`timescale 1ns/100ps
// Overview of operation
// RQ1: sample on tck rise, outputs on fall
// RQ2: tms steers fsm, undriven reads high
// RQ3: tdi enters msb of one selected register
// RQ4: tdo from lsb, driven only while shifting
// RQ5: five tms-high rises force test-logic reset
// RQ6: tap reset never disturbs memory operation
// RQ7: power-up reset, tdo comes up released
// RQ8: three-bit instruction register, serially loaded
// RQ9: identify instruction loaded on any reset
// RQ10: capture-ir loads binary 01 into lsbs
// RQ11: single bypass bit, cleared on capture
// RQ12: boundary register captures ring, then shifts
// RQ13: extest, sample, sample-z capture the ring
// RQ14: boundary order fixed, msb at tdi
// RQ15: identify captures hardwired 32-bit code
// RQ16: controller never issues reserved codes
// RQ17: new instruction applies only at update-ir
// RQ18: unused port keeps tck low
// RQ19: sample-z floats memory outputs until replaced
// RQ20: extest drives preloaded cells onto pins
// RQ21: sample snapshots pins, preload shifts in
// RQ22: standard sixteen-state controller on tms
`include "bst_params.svh"

module bst_tap_dev
  import bst_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  SRST,
  bst_if.dev                         TAP,
  input  wire logic [`BST_BSR_W-1:0] RING_IN,
  output      logic [`BST_BSR_W-1:0] RING_DRIVE,
  output      logic                  EXTEST_EN,
  output      logic                  OUT_HIZ
);

  bst_dev_s q_ff;
  bst_dev_s nxt_q;
  logic     tck_rise;
  logic     tck_fall;
  logic     tms_s;
  logic     tdi_s;
  logic [2:0] pin_raw;
  logic [2:0] pin_s;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  // standard controller transitions
  function automatic bst_tap_e tap_next(input bst_tap_e st,
                                        input logic tms);
    case (st)
      TAP_TLR:    tap_next = tms ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: tap_next = tms ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
      default:    tap_next = TAP_TLR;
    endcase
  endfunction

  // boundary register selected by this instruction
  function automatic logic sel_bsr(input logic [`BST_IR_W-1:0] ir);
    sel_bsr = (ir == `BST_IR_EXTEST) || (ir == `BST_IR_SAMPLE) ||
              (ir == `BST_IR_SAMPLE_Z);
  endfunction

  // identification register selected by this instruction
  function automatic logic sel_id(input logic [`BST_IR_W-1:0] ir);
    sel_id = (ir == `BST_IR_IDCODE);
  endfunction

  // pins cross into the system clock; tms and tdi idle high
  assign pin_raw = {TAP.tck, TAP.tms_pin, TAP.tdi_pin};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      bst_sync #(
        .INIT (i != 2)
      ) u_sync (
        .CLK  (CLK),
        .SRST (SRST),
        .D    (pin_raw[i]),
        .Q    (pin_s[i]),
        .RISE (pin_rise[i]),
        .FALL (pin_fall[i])
      );
    end
  endgenerate

  assign tck_rise = pin_rise[2];
  assign tck_fall = pin_fall[2];
  assign tms_s    = pin_s[1];  // [RQ2]
  assign tdi_s    = pin_s[0];

  // next-state of all tap state
  always_comb begin
    nxt_q = q_ff;
    if (tck_rise) begin
      nxt_q.st = tap_next(q_ff.st, tms_s);  // [RQ1] [RQ22] [RQ5]
      case (q_ff.st)
        TAP_TLR: begin
          nxt_q.ir    = `BST_IR_IDCODE;  // [RQ9]
          nxt_q.ir_sh = `BST_IR_IDCODE;
        end
        TAP_CAP_IR: begin
          nxt_q.ir_sh = `BST_IR_CAPTURE;  // [RQ10]
        end
        TAP_SH_IR: begin
          nxt_q.ir_sh = {tdi_s, q_ff.ir_sh[`BST_IR_W-1:1]};  // [RQ8] [RQ3]
        end
        TAP_UPD_IR: begin
          nxt_q.ir = q_ff.ir_sh;  // [RQ17]
        end
        TAP_CAP_DR: begin
          if (sel_bsr(q_ff.ir)) begin
            nxt_q.bsr = RING_IN;  // [RQ12] [RQ13] [RQ21]
          end else if (sel_id(q_ff.ir)) begin
            nxt_q.idr = `BST_ID_VALUE;  // [RQ15]
          end else begin
            nxt_q.byp = 1'b0;  // [RQ11]
          end
        end
        TAP_SH_DR: begin
          if (sel_bsr(q_ff.ir)) begin
            nxt_q.bsr = {tdi_s, q_ff.bsr[`BST_BSR_W-1:1]};  // [RQ14] [RQ3]
          end else if (sel_id(q_ff.ir)) begin
            nxt_q.idr = {tdi_s, q_ff.idr[`BST_ID_W-1:1]};  // [RQ15]
          end else begin
            nxt_q.byp = tdi_s;  // [RQ11]
          end
        end
        TAP_UPD_DR: begin
          if (sel_bsr(q_ff.ir)) begin
            nxt_q.bsr_upd = q_ff.bsr;  // [RQ21]
          end
        end
        default: begin
        end
      endcase
    end
    // output stage moves only on the falling test clock
    if (tck_fall) begin
      nxt_q.tdo_oe = (q_ff.st == TAP_SH_DR) ||
                     (q_ff.st == TAP_SH_IR);  // [RQ4] [RQ1]
      if (q_ff.st == TAP_SH_IR) begin
        nxt_q.tdo = q_ff.ir_sh[0];  // [RQ4]
      end else if (sel_bsr(q_ff.ir)) begin
        nxt_q.tdo = q_ff.bsr[0];
      end else if (sel_id(q_ff.ir)) begin
        nxt_q.tdo = q_ff.idr[0];
      end else begin
        nxt_q.tdo = q_ff.byp;
      end
    end
  end

  // power-up reset puts the port in test-logic reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      q_ff <= '{st:      TAP_TLR,
                ir:      `BST_IR_IDCODE,
                ir_sh:   `BST_IR_IDCODE,
                byp:     1'b0,
                idr:     `BST_ID_VALUE,
                bsr:     `BST_BSR_RESET,
                bsr_upd: `BST_BSR_RESET,
                tdo:     1'b0,
                tdo_oe:  1'b0};  // [RQ7] [RQ9]
    end else begin
      q_ff <= nxt_q;
    end
  end

  // pin side: only the update latch and instruction decodes touch the memory ring
  assign TAP.tdo    = q_ff.tdo;
  assign TAP.tdo_oe = q_ff.tdo_oe;  // [RQ4] [RQ7]
  assign RING_DRIVE = q_ff.bsr_upd;  // [RQ20]
  assign EXTEST_EN  = (q_ff.ir == `BST_IR_EXTEST);  // [RQ20] [RQ6]
  assign OUT_HIZ    = (q_ff.ir == `BST_IR_SAMPLE_Z);  // [RQ19] [RQ6]

endmodule

/* bst_tap_host.sv */
`timescale 1ns/100ps
`include "bst_params.svh"

module bst_tap_host
  import bst_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SRST,
  bst_if.host              TAP,
  input  wire logic        START,
  input  wire logic        IS_IR,
  input  wire logic [5:0]  LEN,
  input  wire logic [31:0] DIN,
  input  wire logic        TAP_RESET,
  output      logic [31:0] DOUT,
  output      logic        BUSY,
  output      logic        DONE
);

  localparam logic [2:0] HALF_LAST = 3'(`BST_TCK_HALF_CYC - 1);
  localparam logic [5:0] RST_LAST  = 6'(`BST_RESET_TMS_EDGES - 1);

  bst_host_s q_ff;
  bst_host_s nxt_q;
  logic      tdo_s;
  logic [31:0] sh;

  // mode level to present before the next rising edge
  function automatic logic tms_of(input bst_phase_e ph, input logic is_ir,
                                  input logic [5:0] cnt,
                                  input logic [5:0] len);
    case (ph)
      H_RST, H_GO, H_EXIT: tms_of = 1'b1;  // [RQ5]
      H_SDR:               tms_of = is_ir;
      H_SHIFT:             tms_of = (cnt == len - 6'd1);
      default:             tms_of = 1'b0;
    endcase
  endfunction

  bst_sync u_tdo_sync (
    .CLK  (CLK),
    .SRST (SRST),
    .D    (TAP.tdo),
    .Q    (tdo_s),
    .RISE (),
    .FALL ()
  );

  assign sh = {tdo_s, q_ff.dout[31:1]};

  // sequencer, test clock divided from the system clock
  always_comb begin
    nxt_q      = q_ff;
    nxt_q.done = 1'b0;
    if (q_ff.ph == H_IDLE) begin
      if (TAP_RESET) begin
        nxt_q.ph  = H_RST;
        nxt_q.cnt = 6'd0;
        nxt_q.tms = 1'b1;
        nxt_q.div = 3'd0;
      end else if (START) begin
        nxt_q.ph    = H_GO;
        nxt_q.is_ir = IS_IR;
        nxt_q.len   = (LEN == 6'd0) ? 6'd1 : LEN;
        nxt_q.din   = DIN;
        nxt_q.cnt   = 6'd0;
        nxt_q.div   = 3'd0;
        nxt_q.tms   = tms_of(H_GO, IS_IR, 6'd0, LEN);
      end
    end else if (q_ff.div != HALF_LAST) begin
      nxt_q.div = q_ff.div + 3'd1;
    end else begin
      nxt_q.div = 3'd0;
      nxt_q.tck = ~q_ff.tck;
      if (q_ff.tck) begin
        // falling edge: change drive levels, or park the clock low
        if (q_ff.ph == H_END) begin
          nxt_q.ph   = H_IDLE;
          nxt_q.tck  = 1'b0;
          nxt_q.done = 1'b1;
        end else begin
          nxt_q.tms = tms_of(q_ff.ph, q_ff.is_ir, q_ff.cnt, q_ff.len);
          nxt_q.tdi = q_ff.din[0];
          // synced tdo lags more than a half period: take the bit here, not at rise
          if (q_ff.ph == H_EXIT) begin
            nxt_q.dout = sh >> (6'd32 - q_ff.len);
          end else if (q_ff.ph == H_SHIFT && q_ff.cnt != 6'd0) begin
            nxt_q.dout = sh;
          end
        end
      end else begin
        // rising edge: device samples, host advances its phase and shifts din
        case (q_ff.ph)
          H_RST: begin
            nxt_q.cnt = q_ff.cnt + 6'd1;
            if (q_ff.cnt == RST_LAST) begin
              nxt_q.ph = H_RTI;  // [RQ5]
            end
          end
          H_RTI:   nxt_q.ph = H_END;
          H_GO:    nxt_q.ph = H_SDR;
          H_SDR:   nxt_q.ph = q_ff.is_ir ? H_SIR : H_CAP;
          H_SIR:   nxt_q.ph = H_CAP;
          H_CAP:   nxt_q.ph = H_SHIFT;
          H_SHIFT: begin
            nxt_q.din = {1'b0, q_ff.din[31:1]};
            nxt_q.cnt = q_ff.cnt + 6'd1;
            if (q_ff.cnt == q_ff.len - 6'd1) begin
              nxt_q.ph = H_EXIT;
            end
          end
          H_EXIT:  nxt_q.ph = H_UPD;
          H_UPD:   nxt_q.ph = H_END;  // [RQ17]
          default: nxt_q.ph = H_END;
        endcase
      end
    end
  end

  // reset starts with a tms-high test-logic reset sequence
  always_ff @(posedge CLK) begin
    if (SRST) begin
      q_ff <= '{ph: H_RST, tck: 1'b0, tms: 1'b1, tdi: 1'b1, div: 3'd0,
                cnt: 6'd0, len: 6'd1, is_ir: 1'b0, din: 32'h00000000,
                dout: 32'h00000000, done: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // idle keeps tck low so the port is never clocked
  assign TAP.tck    = q_ff.tck;  // [RQ18]
  assign TAP.tms    = q_ff.tms;
  assign TAP.tms_oe = 1'b1;
  assign TAP.tdi    = q_ff.tdi;
  assign TAP.tdi_oe = 1'b1;
  assign DOUT       = q_ff.dout;
  assign DONE       = q_ff.done;
  assign BUSY       = (q_ff.ph != H_IDLE);

endmodule

/* bst_tap_props.sv */
`timescale 1ns/100ps
`include "bst_params.svh"

module bst_tap_props
  import bst_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic tck,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // next state per state, one nibble each, for mode low and mode high
  localparam logic [63:0] NX0 = 64'h1BDDBBA146644311;
  localparam logic [63:0] NX1 = 64'h2FEFCC0287855920;
  localparam logic [31:0] ID  = `BST_ID_VALUE;
  logic       tck_q, rise, fall, exp_oe, tdi_q, byp;
  logic [3:0] st;
  logic [2:0] ir, ir_sh, c5;
  logic [5:0] n;

  // test clock edges; bypass path also for the unused codes
  assign rise = tck & ~tck_q;
  assign fall = ~tck & tck_q;
  assign byp  = (ir == 3'h3) | (ir[2] & (ir[1] | ir[0]));

  // mirror of the controller, stepped on each test clock rise
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tck_q  <= 1'b0;
      st     <= TAP_TLR;
      ir     <= `BST_IR_IDCODE;
      ir_sh  <= 3'h0;
      n      <= 6'h00;
      c5     <= 3'h0;
      tdi_q  <= 1'b0;
      exp_oe <= 1'b0;
    end else begin
      tck_q <= tck;
      if (fall)
        exp_oe <= (st == TAP_SH_DR) || (st == TAP_SH_IR);
      if (rise) begin
        st    <= tms_pin ? NX1[{st, 2'h0} +: 4] : NX0[{st, 2'h0} +: 4];
        n     <= (st == TAP_SH_DR || st == TAP_SH_IR) ? n + 6'h01 : 6'h00;
        c5    <= !tms_pin ? 3'h0 : (c5 == 3'h7) ? c5 : c5 + 3'h1;
        tdi_q <= tdi_pin;
        if (st == TAP_SH_IR)
          ir_sh <= {tdi_pin, ir_sh[2:1]};
        if (st == TAP_UPD_IR)
          ir <= ir_sh;
        if (st == TAP_TLR)
          ir <= `BST_IR_IDCODE;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence shift_dr_s;
    rise && st == TAP_SH_DR;
  endsequence

  tdo_edge_a: assert property (($changed(tdo) || $changed(tdo_oe)) |-> !tck)
    else $error("tdo moved while test clock high");
  oe_shift_a: assert property (rise |-> tdo_oe == exp_oe)
    else $error("tdo enable not matching shift state");
  reset_five_a: assert property (c5 >= 3'h5 |-> !tdo_oe)
    else $error("tdo driven after five mode-high rises");
  boot_float_a: assert property ($fell(SRST) |-> !tdo_oe [*8])
    else $error("tdo driven just after reset");
  capir_bits_a: assert property (rise && st == TAP_SH_IR && n < 6'h02 |-> tdo == (n == 6'h00))
    else $error("instruction capture pattern wrong");
  idcode_out_a: assert property (shift_dr_s ##0 (ir == `BST_IR_IDCODE && n < 6'h20) |-> tdo == ID[n[4:0]])
    else $error("identification bit wrong");
  byp_zero_a: assert property (shift_dr_s ##0 (byp && n == 6'h00) |-> !tdo)
    else $error("bypass bit not cleared");
  byp_path_a: assert property (shift_dr_s ##0 (byp && n != 6'h00) |-> tdo == tdi_q)
    else $error("bypass path not one bit");
endmodule

/* tb_sram_boundary_scan_tap.sv */
`timescale 1ns/100ps
`include "bst_params.svh"

module tb_sram_boundary_scan_tap import bst_pkg::*;;
  logic        clk, srst, start, is_ir, tap_reset, busy, done;
  logic        extest_en, out_hiz, mid_hiz;
  logic [5:0]  len_i;
  logic [31:0] din, dout, d;
  logic [23:0] ring_in, ring_drive, last_d;
  logic [2:0]  codes [3];
  int          bad_count, check_count, seed;

  bst_if i_if();
  bst_if i_if2();
  bst_tap_dev i_bst_tap_dev(.CLK(clk), .SRST(srst), .TAP(i_if),
    .RING_IN(ring_in), .RING_DRIVE(ring_drive), .EXTEST_EN(extest_en),
    .OUT_HIZ(out_hiz));
  bst_tap_host i_bst_tap_host(.CLK(clk), .SRST(srst), .TAP(i_if),
    .START(start), .IS_IR(is_ir), .LEN(len_i), .DIN(din),
    .TAP_RESET(tap_reset), .DOUT(dout), .BUSY(busy), .DONE(done));
  bst_tap_props i_bst_tap_props(.CLK(clk), .SRST(srst), .tck(i_if.tck),
    .tms_pin(i_if.tms_pin), .tdi_pin(i_if.tdi_pin), .tdo(i_if.tdo),
    .tdo_oe(i_if.tdo_oe));

  // unused port: test clock held low, mode and data left floating
  assign i_if2.tck    = 1'b0;
  assign i_if2.tms    = 1'b0;
  assign i_if2.tms_oe = 1'b0;
  assign i_if2.tdi    = 1'b0;
  assign i_if2.tdi_oe = 1'b0;
  bst_tap_dev i_bst_tap_dev_idle(.CLK(clk), .SRST(srst), .TAP(i_if2),
    .RING_IN(24'h000000), .RING_DRIVE(), .EXTEST_EN(), .OUT_HIZ());

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_b(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  function automatic logic [31:0] msk(input logic [5:0] n);
    return (n == 6'h20) ? 32'hFFFFFFFF : ((32'h1 << n) - 32'h1);
  endfunction

  // bypass delays the stream one bit, first bit out is the cleared cell
  function automatic logic [31:0] byp_exp(input logic [31:0] v,
                                          input logic [5:0]  n);
    return {v[30:0], 1'b0} & msk(n);
  endfunction

  // one host transfer; a length of zero asks for a tap reset instead
  task scan(input logic ir, input logic [5:0] n, input logic [31:0] v);
    int k;
    k = 0;
    is_ir = ir;
    len_i = n;
    din = v;
    if (n == 6'h00)
      tap_reset = 1'b1;
    else
      start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    tap_reset = 1'b0;
    while (done !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
      if (k == 40)
        mid_hiz = out_hiz;
    end
    if (k >= 2000) begin
      bad_count++;
      conclude;
    end
    @(negedge clk);
  endtask

  task ir_set(input logic [2:0] code);
    scan(1'b1, 6'h03, {29'h0, code});
    chk_w("ir capture", 32'h1, dout & 32'h3);
  endtask

  // boundary instruction: mode flags, held drive, capture and update
  task bnd(input logic [2:0] code);
    logic [31:0] r;
    ir_set(code);
    chk_b("extest flag", code == `BST_IR_EXTEST, extest_en);
    chk_b("float flag", code == `BST_IR_SAMPLE_Z, out_hiz);
    chk_w("held drive", {8'h0, last_d}, {8'h0, ring_drive});
    r = $random(seed);
    d = $random(seed);
    ring_in = r[23:0];
    scan(1'b0, 6'h18, d);
    chk_w("ring capture", r & msk(6'h18), dout & msk(6'h18));
    chk_w("ring drive", d & msk(6'h18), {8'h0, ring_drive});
    last_d = d[23:0];
  endtask

  initial begin
    #600000;
    bad_count++;
    conclude;
  end

  initial begin
    seed = 32'h20D4;
    srst = 1'b1;
    {start, is_ir, tap_reset, mid_hiz} = 4'h0;
    len_i = 6'h00;
    din = 32'h0;
    ring_in = 24'h000000;
    last_d = 24'h000000;
    codes = '{`BST_IR_SAMPLE, `BST_IR_EXTEST, `BST_IR_SAMPLE_Z};
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    for (int k = 0; k < 1000 && busy !== 1'b0; k++)
      @(negedge clk);
    scan(1'b0, 6'h20, $random(seed));
    chk_w("boot id", `BST_ID_VALUE, dout);
    chk_b("boot float", 1'b0, out_hiz);
    $display("test boot finished");
    ir_set(`BST_IR_BYPASS);
    for (int i = 0; i < 4; i++) begin
      len_i = (i == 0) ? 6'h01 : (i == 1) ? 6'h20 : 6'(($random(seed) & 31) + 1);
      d = $random(seed);
      scan(1'b0, len_i, d);
      chk_w("bypass", byp_exp(d, len_i), dout & msk(len_i));
    end
    $display("test bypass finished");
    for (int i = 0; i < 3; i++)
      bnd(codes[i]);
    $display("test boundary finished");
    ir_set(`BST_IR_IDCODE);
    chk_b("float mid scan", 1'b1, mid_hiz);
    chk_b("float released", 1'b0, out_hiz);
    scan(1'b0, 6'h20, 32'h0);
    chk_w("id again", `BST_ID_VALUE, dout);
    $display("test update finished");
    ir_set(`BST_IR_EXTEST);
    scan(1'b0, 6'h00, 32'h0);
    chk_b("extest cleared", 1'b0, extest_en);
    scan(1'b0, 6'h20, 32'h0);
    chk_w("id after reset", `BST_ID_VALUE, dout);
    chk_b("idle port tdo", 1'b0, i_if2.tdo_oe);
    $display("test reset finished");
    conclude;
  end
endmodule
